// ---- shared/irq_flags_pkg.sv ----
// Purpose: Constants shared by the peripheral event flag block
// Assumes: APB with 32-bit data, byte addresses on paddr
// Notes: Flag register printed offset is a word index, byte address is four times it
package irq_flags_pkg;
   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Word index of the flag register and its byte address
   localparam logic [7:0] FLAGS_INDEX = 8'h16;
   localparam logic [7:0] FLAGS_ADDR = 8'(FLAGS_INDEX * 8'h04);
   // Byte addresses of the supporting registers
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] T1_PERIOD_ADDR = 8'h04;
   localparam logic [7:0] T2_PERIOD_ADDR = 8'h08;
   localparam logic [7:0] T3_PERIOD_ADDR = 8'h0C;
   localparam logic [7:0] CHANGE_PORT_ADDR = 8'h10;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h18;
   // Flag bit positions
   localparam int BIT_CHANGE = 7;
   localparam int BIT_T3 = 6;
   localparam int BIT_T2 = 5;
   localparam int BIT_T1 = 4;
   localparam int BIT_CAP2 = 3;
   localparam int BIT_CAP1 = 2;
   localparam int BIT_TX = 1;
   localparam int BIT_RX = 0;
   // Control bit positions
   localparam int CTRL_CAP1_SEL = 0;
   localparam int CTRL_WIDE = 1;
   localparam int CTRL_GDIS = 2;
   // Reset values and masks
   localparam logic [7:0] FLAGS_RESET = 8'h02;
   localparam logic [7:0] FLAGS_WR_MASK = 8'hFC;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [15:0] T3_MAX = 16'hFFFF;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// ---- rtl/bit_sync.sv ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw and synchronised levels
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // Metastability catcher, read by the second stage alone
   logic [WIDTH-1:0] stage1;

   // Both stages clear at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// ---- rtl/peripheral_irq_flags.sv ----
// Purpose: Peripheral event flag register with APB access and one interrupt line
// Assumes: Timer counts and buffer levels come from logic on pclk; pins are asynchronous
// Notes: Flags latch whatever the enables; interrupt output lags status by one cycle
// How it works
// - Flags set regardless of any enable
// - Bit 7 sets on change port mismatch
// - Capture mode: bit 6 on timer3 overflow
// - Period mode: bit 6 on period rollover
// - Bit 5 on timer2 period rollover
// - Narrow mode: bit 4 on timer1 rollover
// - Wide mode: bit 4 on pair rollover
// - Bit 3 on capture2 pin event
// - Bit 2 on capture1 pin event
// - Bit 1 shows transmit buffer empty
// - Bit 0 shows receive buffer full
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module peripheral_irq_flags #(
   parameter int CHANGE_WIDTH = 4
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [irq_flags_pkg::ADDR_W-1:0] paddr,
   input wire logic [irq_flags_pkg::DATA_W-1:0] pwdata,
   output logic [irq_flags_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [CHANGE_WIDTH-1:0] change_port,
   input wire logic capture1_pin,
   input wire logic capture2_pin,
   // Timer counts
   input wire logic [7:0] timer1_count,
   input wire logic [7:0] timer2_count,
   input wire logic [15:0] timer3_count,
   // Serial buffer levels
   input wire logic tx_buffer_full,
   input wire logic rx_buffer_full,
   // Results
   output logic [7:0] peripheral_event_flags,
   output logic capture1_select,
   output logic timer_wide_mode,
   output logic global_irq_disable,
   output logic irq
);
   import irq_flags_pkg::*;

   // Synchronised pins
   logic [CHANGE_WIDTH-1:0] port_sync;
   logic [1:0] cap_sync;
   // Stored state
   logic [CHANGE_WIDTH-1:0] port_latch;
   logic [1:0] cap_prev;
   logic [7:0] t1_prev;
   logic [7:0] t2_prev;
   logic [15:0] t3_prev;
   logic [7:0] timer1_period;
   logic [7:0] timer2_period;
   logic [15:0] timer3_period_pair;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   // Next values
   logic [DATA_W-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [7:0] next_flags;
   logic next_cap1_sel;
   logic next_wide;
   logic next_gdis;
   logic next_irq;
   logic [CHANGE_WIDTH-1:0] next_port_latch;
   logic [7:0] next_t1_period;
   logic [7:0] next_t2_period;
   logic [15:0] next_t3_period;
   logic [7:0] next_status;
   logic [7:0] next_mask;
   // Decoded strobes and events
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic mismatch;
   logic t1_narrow_roll;
   logic t1_wide_roll;
   logic t2_roll;
   logic t3_overflow;
   logic t3_period_roll;
   logic [7:0] ev;

   // Pin synchronisers
   bit_sync #(.WIDTH(CHANGE_WIDTH)) u_port_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(change_port),
      .dout(port_sync)
   );

   bit_sync #(.WIDTH(2)) u_cap_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({capture2_pin, capture1_pin}),
      .dout(cap_sync)
   );

   // Transfer completes at the access edge; pready is high only there
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;

   // Event detection from previous and present samples
   always_comb begin
      // Mismatch holds while the port differs from the value latched at the last port read
      mismatch = (port_sync != port_latch);
      t1_narrow_roll = (t1_prev == timer1_period) && (timer1_count == BYTE_ZERO);
      t1_wide_roll = ({t2_prev, t1_prev} == {timer2_period, timer1_period}) &&
                     ({timer2_count, timer1_count} == HALF_ZERO);
      t2_roll = (t2_prev == timer2_period) && (timer2_count == BYTE_ZERO);
      t3_overflow = (t3_prev == T3_MAX) && (timer3_count == HALF_ZERO);
      t3_period_roll = (t3_prev == timer3_period_pair) && (timer3_count == HALF_ZERO);
      ev = BYTE_ZERO;
      ev[BIT_CHANGE] = mismatch;
      // Source depends on capture1 mode
      ev[BIT_T3] = capture1_select ? t3_overflow : t3_period_roll;
      ev[BIT_T2] = t2_roll;
      // Source depends on timer width
      ev[BIT_T1] = timer_wide_mode ? t1_wide_roll : t1_narrow_roll;
      // Rising edges count as capture events
      ev[BIT_CAP2] = cap_sync[1] & ~cap_prev[1];
      ev[BIT_CAP1] = cap_sync[0] & ~cap_prev[0];
      // Level flags raise a status event only on entry
      ev[BIT_TX] = ~tx_buffer_full & ~peripheral_event_flags[BIT_TX];
      ev[BIT_RX] = rx_buffer_full & ~peripheral_event_flags[BIT_RX];
   end

   // Register next values and read decode
   always_comb begin
      next_flags = peripheral_event_flags;
      next_cap1_sel = capture1_select;
      next_wide = timer_wide_mode;
      next_gdis = global_irq_disable;
      next_port_latch = port_latch;
      next_t1_period = timer1_period;
      next_t2_period = timer2_period;
      next_t3_period = timer3_period_pair;
      next_status = irq_status;
      next_mask = irq_mask;
      next_prdata = prdata;
      next_pready = psel & ~penable;
      next_pslverr = 1'b0;
      mapped = 1'b1;
      // Writes land at the access edge only
      if (wr && paddr == FLAGS_ADDR) begin
         // Read-only low bits keep hardware values
         next_flags = (peripheral_event_flags & ~FLAGS_WR_MASK) | (pwdata[7:0] & FLAGS_WR_MASK);
      end else if (wr && paddr == CTRL_ADDR) begin
         next_cap1_sel = pwdata[CTRL_CAP1_SEL];
         next_wide = pwdata[CTRL_WIDE];
         next_gdis = pwdata[CTRL_GDIS];
      end else if (wr && paddr == T1_PERIOD_ADDR) begin
         next_t1_period = pwdata[7:0];
      end else if (wr && paddr == T2_PERIOD_ADDR) begin
         next_t2_period = pwdata[7:0];
      end else if (wr && paddr == T3_PERIOD_ADDR) begin
         next_t3_period = pwdata[15:0];
      end else if (wr && paddr == IRQ_STATUS_ADDR) begin
         // Write one to clear
         next_status = irq_status & ~pwdata[7:0];
      end else if (wr && paddr == IRQ_MASK_ADDR) begin
         next_mask = pwdata[7:0];
      end else if (rd && paddr == CHANGE_PORT_ADDR) begin
         // Reading the port takes a new reference, ending the mismatch
         next_port_latch = port_sync;
      end
      // Hardware sets override any write, whatever the enables say
      next_flags = next_flags | (ev & FLAGS_WR_MASK);
      next_flags[BIT_TX] = ~tx_buffer_full;
      next_flags[BIT_RX] = rx_buffer_full;
      next_status = next_status | ev;
      // Read data captured in the setup cycle
      if (psel && !penable) begin
         if (paddr == FLAGS_ADDR) begin
            next_prdata = {24'h00_0000, peripheral_event_flags};
         end else if (paddr == CTRL_ADDR) begin
            next_prdata = {29'h0000_0000, global_irq_disable, timer_wide_mode, capture1_select};
         end else if (paddr == T1_PERIOD_ADDR) begin
            next_prdata = {24'h00_0000, timer1_period};
         end else if (paddr == T2_PERIOD_ADDR) begin
            next_prdata = {24'h00_0000, timer2_period};
         end else if (paddr == T3_PERIOD_ADDR) begin
            next_prdata = {16'h0000, timer3_period_pair};
         end else if (paddr == CHANGE_PORT_ADDR) begin
            next_prdata = DATA_W'(port_sync);
         end else if (paddr == IRQ_STATUS_ADDR) begin
            next_prdata = {24'h00_0000, irq_status};
         end else if (paddr == IRQ_MASK_ADDR) begin
            next_prdata = {24'h00_0000, irq_mask};
         end else begin
            // Unmapped address answers zero with an error
            next_prdata = WORD_ZERO;
            mapped = 1'b0;
         end
         next_pslverr = ~mapped;
      end
      // Line follows unmasked status, silenced by the global disable
      next_irq = (|(irq_status & irq_mask)) & ~global_irq_disable;
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= WORD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
         peripheral_event_flags <= FLAGS_RESET;
         capture1_select <= 1'b0;
         timer_wide_mode <= 1'b0;
         global_irq_disable <= 1'b0;
         irq <= 1'b0;
         port_latch <= '0;
         cap_prev <= 2'h0;
         t1_prev <= BYTE_ZERO;
         t2_prev <= BYTE_ZERO;
         t3_prev <= HALF_ZERO;
         timer1_period <= BYTE_ZERO;
         timer2_period <= BYTE_ZERO;
         timer3_period_pair <= HALF_ZERO;
         irq_status <= BYTE_ZERO;
         irq_mask <= BYTE_ZERO;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         peripheral_event_flags <= next_flags;
         capture1_select <= next_cap1_sel;
         timer_wide_mode <= next_wide;
         global_irq_disable <= next_gdis;
         irq <= next_irq;
         port_latch <= next_port_latch;
         cap_prev <= cap_sync;
         t1_prev <= timer1_count;
         t2_prev <= timer2_count;
         t3_prev <= timer3_count;
         timer1_period <= next_t1_period;
         timer2_period <= next_t2_period;
         timer3_period_pair <= next_t3_period;
         irq_status <= next_status;
         irq_mask <= next_mask;
      end
   end

   // Checks on the flag logic
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flags_ignore_enable: assert property (
      (ev & FLAGS_WR_MASK) != BYTE_ZERO && global_irq_disable |=>
      (peripheral_event_flags & $past(ev & FLAGS_WR_MASK)) == $past(ev & FLAGS_WR_MASK))
      else $error("flag not set while disabled");
   a_change_mismatch: assert property (mismatch |=> peripheral_event_flags[BIT_CHANGE])
      else $error("change flag missed");
   a_t3_overflow_set: assert property (
      capture1_select && t3_prev == T3_MAX && timer3_count == HALF_ZERO |=> peripheral_event_flags[BIT_T3])
      else $error("timer3 overflow flag missed");
   a_t3_period_set: assert property (
      !capture1_select && t3_prev == timer3_period_pair && timer3_count == HALF_ZERO
      |=> peripheral_event_flags[BIT_T3])
      else $error("timer3 period flag missed");
   a_t2_roll_set: assert property (
      t2_prev == timer2_period && timer2_count == BYTE_ZERO |=> peripheral_event_flags[BIT_T2])
      else $error("timer2 flag missed");
   a_t1_narrow_set: assert property (
      !timer_wide_mode && t1_prev == timer1_period && timer1_count == BYTE_ZERO
      |=> peripheral_event_flags[BIT_T1])
      else $error("timer1 narrow flag missed");
   a_t1_wide_set: assert property (
      timer_wide_mode && {t2_prev, t1_prev} == {timer2_period, timer1_period} &&
      {timer2_count, timer1_count} == HALF_ZERO |=> peripheral_event_flags[BIT_T1])
      else $error("timer1 wide flag missed");
   a_capture_two: assert property (
      $rose(cap_sync[1]) |=> peripheral_event_flags[BIT_CAP2])
      else $error("capture2 flag missed");
   a_capture_one: assert property (
      $rose(cap_sync[0]) |=> peripheral_event_flags[BIT_CAP1])
      else $error("capture1 flag missed");
   a_tx_level: assert property (peripheral_event_flags[BIT_TX] == !$past(tx_buffer_full))
      else $error("transmit flag wrong");
   a_rx_level: assert property (peripheral_event_flags[BIT_RX] == $past(rx_buffer_full))
      else $error("receive flag wrong");
   a_write_lands: assert property (
      wr && paddr == FLAGS_ADDR && ev == BYTE_ZERO |=>
      peripheral_event_flags[7:2] == $past(pwdata[7:2]))
      else $error("flag write lost");
   a_set_wins: assert property (
      wr && paddr == FLAGS_ADDR && ev[BIT_CHANGE] |=> peripheral_event_flags[BIT_CHANGE])
      else $error("write beat hardware set");
   a_irq_follows: assert property (
      irq == $past((|(irq_status & irq_mask)) & ~global_irq_disable))
      else $error("interrupt line wrong");

   c_change_seen: cover property (mismatch ##1 rd && paddr == CHANGE_PORT_ADDR ##2 !mismatch);
   c_t3_overflow: cover property (capture1_select && t3_overflow);
   c_write_clash: cover property (wr && paddr == FLAGS_ADDR && ev != BYTE_ZERO);
   c_irq_rise: cover property ($rose(irq));
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the peripheral event flag block over APB
// Assumes: Zero-wait APB slave, flags visible on the result port
// Notes: Timer and pin stimulus is driven directly; no far-side model
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
   import irq_flags_pkg::*;
   // Clock, reset and APB master signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   // Pins, timers and serial levels
   logic [3:0] change_port = 4'h0;
   logic capture1_pin = 1'b0, capture2_pin = 1'b0;
   // Idle counts sit off zero, so a still timer never looks like a rollover
   logic [7:0] timer1_count = 8'h01, timer2_count = 8'h01;
   logic [15:0] timer3_count = 16'h0001;
   logic tx_buffer_full = 1'b0, rx_buffer_full = 1'b0;
   // Results
   logic [7:0] flags;
   logic capture1_select, timer_wide_mode, global_irq_disable, irq;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int n_tests = 0;

   // 25 MHz clock
   always #20 pclk = ~pclk;

   peripheral_irq_flags peripheral_irq_flags_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .change_port(change_port), .capture1_pin(capture1_pin), .capture2_pin(capture2_pin),
      .timer1_count(timer1_count), .timer2_count(timer2_count), .timer3_count(timer3_count),
      .tx_buffer_full(tx_buffer_full), .rx_buffer_full(rx_buffer_full),
      .peripheral_event_flags(flags), .capture1_select(capture1_select),
      .timer_wide_mode(timer_wide_mode), .global_irq_disable(global_irq_disable), .irq(irq)
   );

   // Closing verdict, the one exit of the run
   task automatic results();
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; waits for pready, no cycle count assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      // Answer taken at the sampling edge, then released
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic e_err);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
      `CHK(err, e_err)
   endtask

   // Clear flags, present a timer pair of samples, then check one flag bit
   task automatic ev(input logic [7:0] a1, a2, input logic [15:0] a3,
                     input logic [7:0] b1, b2, input logic [15:0] b3, input int b, input logic e);
      wr(FLAGS_ADDR, 32'h0000_0000);
      @(posedge pclk);
      timer1_count <= a1;
      timer2_count <= a2;
      timer3_count <= a3;
      @(posedge pclk);
      timer1_count <= b1;
      timer2_count <= b2;
      timer3_count <= b3;
      @(posedge pclk);
      // Back to idle counts, which end no period
      timer1_count <= 8'h01;
      timer2_count <= 8'h01;
      timer3_count <= 16'h0001;
      step(2);
      `CHK(flags[b], e)
   endtask

   // Watchdog, far beyond the two hundred or so cycles the tests need
   initial begin
      #400us;
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end

   initial begin
      step(3);
      presetn <= 1'b1;
      step(1);
      // Reset value and read-only low bits
      rdc(FLAGS_ADDR, 32'h0000_0002, 1'b0);
      rdc(8'h40, 32'h0000_0000, 1'b1);
      wr(FLAGS_ADDR, 32'hFFFF_FFFF);
      rdc(FLAGS_ADDR, 32'h0000_00FE, 1'b0);
      wr(FLAGS_ADDR, 32'h0000_0000);
      rdc(FLAGS_ADDR, 32'h0000_0002, 1'b0);
      // Serial buffer levels, both states
      @(posedge pclk);
      tx_buffer_full <= 1'b1;
      rx_buffer_full <= 1'b1;
      step(3);
      `CHK(flags[1:0], 2'b01)
      tx_buffer_full <= 1'b0;
      rx_buffer_full <= 1'b0;
      step(3);
      `CHK(flags[1:0], 2'b10)
      // Timer2 event latches under global disable with mask clear
      wr(CTRL_ADDR, 32'h0000_0004);
      step(1);
      `CHK({global_irq_disable, timer_wide_mode, capture1_select}, 3'b100)
      wr(T2_PERIOD_ADDR, 32'h0000_0005);
      ev(8'h00, 8'h05, 16'h0000, 8'h00, 8'h00, 16'h0000, BIT_T2, 1'b1);
      `CHK(irq, 1'b0)
      ev(8'h00, 8'h04, 16'h0000, 8'h00, 8'h00, 16'h0000, BIT_T2, 1'b0);
      // Interrupt masked, then unmasked, then status cleared
      wr(CTRL_ADDR, 32'h0000_0000);
      step(2);
      `CHK(irq, 1'b0)
      wr(FLAGS_ADDR, 32'h0000_0000);
      wr(IRQ_MASK_ADDR, 32'h0000_0020);
      step(2);
      `CHK(irq, 1'b1)
      rdc(IRQ_MASK_ADDR, 32'h0000_0020, 1'b0);
      wr(IRQ_STATUS_ADDR, 32'h0000_0020);
      step(2);
      `CHK(irq, 1'b0)
      // Timer1 narrow and wide mode
      wr(T1_PERIOD_ADDR, 32'h0000_0033);
      ev(8'h33, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, BIT_T1, 1'b1);
      ev(8'h32, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, BIT_T1, 1'b0);
      wr(CTRL_ADDR, 32'h0000_0002);
      ev(8'h33, 8'h01, 16'h0000, 8'h00, 8'h01, 16'h0000, BIT_T1, 1'b0);
      ev(8'h33, 8'h05, 16'h0000, 8'h00, 8'h00, 16'h0000, BIT_T1, 1'b1);
      // Timer3 overflow mode and period mode
      wr(T3_PERIOD_ADDR, 32'h0000_1234);
      wr(CTRL_ADDR, 32'h0000_0001);
      ev(8'h00, 8'h00, 16'h1234, 8'h00, 8'h00, 16'h0000, BIT_T3, 1'b0);
      ev(8'h00, 8'h00, 16'hFFFF, 8'h00, 8'h00, 16'h0000, BIT_T3, 1'b1);
      wr(CTRL_ADDR, 32'h0000_0000);
      ev(8'h00, 8'h00, 16'hFFFF, 8'h00, 8'h00, 16'h0000, BIT_T3, 1'b0);
      ev(8'h00, 8'h00, 16'h1234, 8'h00, 8'h00, 16'h0000, BIT_T3, 1'b1);
      // Capture pins, rising edges
      wr(FLAGS_ADDR, 32'h0000_0000);
      step(1);
      `CHK(flags[3:2], 2'b00)
      @(posedge pclk);
      capture1_pin <= 1'b1;
      step(5);
      `CHK(flags[3:2], 2'b01)
      capture2_pin <= 1'b1;
      step(5);
      `CHK(flags[3:2], 2'b11)
      // Change port mismatch and its removal by reading the port
      change_port <= 4'h5;
      step(5);
      `CHK(flags[7], 1'b1)
      rdc(CHANGE_PORT_ADDR, 32'h0000_0005, 1'b0);
      wr(FLAGS_ADDR, 32'h0000_0000);
      step(3);
      `CHK(flags[7], 1'b0)
      results();
   end
endmodule
